// ==== hw/pid_sleep_pkg.sv ====
// package for the pid sleep / integral hold / monitor block
// assumes one 250 MHz clock; percentages are signed counts of 0.1 %
package pid_sleep_pkg;
    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam longint TICK_NS = 64'd100_000_000;  // sleep timer step, 0.1 s
    localparam int TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);
    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFS_ACTION = 8'h00;
    localparam logic [7:0] OFS_DET_TIME = 8'h04;
    localparam logic [7:0] OFS_DET_LEVEL = 8'h08;
    localparam logic [7:0] OFS_REL_LEVEL = 8'h0C;
    localparam logic [7:0] OFS_FAULT_ACT = 8'h10;
    localparam logic [7:0] OFS_HOLD_SEL = 8'h14;
    localparam logic [7:0] OFS_NEG_SEL = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1C;
    localparam logic [7:0] OFS_MON_SEL = 8'h20;
    localparam logic [7:0] OFS_TERM_FUNC = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
    // =========================================================
    // field positions
    localparam int CTRL_EN_ASSIGNED = 0;
    localparam int MON_PANEL_LSB = 0;
    localparam int MON_ANALOG_LSB = 8;
    localparam int MON_PULSE_LSB = 16;
    localparam int IRQ_SLEEP_IN = 0;
    localparam int IRQ_SLEEP_OUT = 1;
    localparam int IRQ_HOLD = 2;
    localparam int IRQ_W = 3;
    // =========================================================
    // reset values and codes
    localparam logic [15:0] DET_TIME_OFF = 16'h270F;     // 9999, sleep off
    localparam logic [15:0] RST_DET_TIME = DET_TIME_OFF;
    localparam logic [15:0] RST_ACTION = 16'h0000;
    localparam logic [7:0] FAULT_COAST_MAX = 8'h03;
    localparam logic [7:0] FAULT_DECEL_MIN = 8'h0A;
    localparam logic [7:0] FAULT_DECEL_MAX = 8'h0D;
    localparam logic [1:0] HOLD_LIMIT_PM = 2'h0;
    localparam logic [1:0] HOLD_NONE = 2'h1;
    localparam logic [1:0] HOLD_LIMIT_POS = 2'h2;
    localparam logic [7:0] TERM_POS = 8'h46;             // 70
    localparam logic [7:0] TERM_NEG = 8'hAA;             // 170
    localparam logic [7:0] MON_SET_POINT = 8'h34;        // 52
    localparam logic [7:0] MON_MEASURED = 8'h35;         // 53
    localparam logic [7:0] MON_MEASURED2 = 8'h43;        // 67
    localparam logic [7:0] MON_DEVIATION = 8'h36;        // 54
    localparam logic [7:0] MON_MANIP = 8'h5B;            // 91
    localparam logic signed [16:0] PCT_100 = 17'sh003E8;  // 100 %
    localparam logic signed [16:0] PCT_0 = 17'sh00000;
    localparam logic signed [16:0] PCT_1000 = 17'sh02710; // 1000 % offset
    localparam logic signed [16:0] PANEL_MIN = 17'sh02328; // 900 %
    localparam logic signed [16:0] PANEL_MAX = 17'sh02AF8; // 1100 %
    // =========================================================
    // types
    typedef enum logic [1:0] {S_RUN, S_DECEL, S_SLEEP} sleep_state_t;
    typedef struct packed {
        logic signed [15:0] set_point;
        logic signed [15:0] measured;
        logic signed [15:0] deviation;
        logic signed [15:0] manip;
    } pid_quant_t;
    typedef struct packed {
        logic signed [16:0] panel;
        logic signed [16:0] analog;
        logic signed [16:0] pulse;
        logic pulse_valid;
    } monitor_out_t;
endpackage

// ==== hw/pid_sleep_ctrl.sv ====
// sleep, integral hold, pid monitor and pid enable logic of a drive
// assumes the pid calculation feeds quantities synchronous to clk_i and
// software drives the avalon-mm slave port
//
// Notes on behaviour
// - suspend after low frequency lasts detection time
// - wake when deviation reaches release minus 1000%
// - sleep entry coasts or decelerates per fault action
// - action 0-3 coast, 10-13 decelerate
// - sleep only when detection time not 9999
// - asleep: sleep flag on, running off, pid on
// - sleep terminal code 70 positive, 170 negative
// - release during decel re-accelerates; level ignored
// - hold select 0,1,2 picks hold and range
// - select 1 holds at upper, +100%, -100%
// - hold at limits, +-100% or 0/100%
// - panel shows deviation/amount offset by 1000
// - pulse terminal gets no deviation or amount
// - codes 52,53,67,54,91 pick quantities
// - measured 2 ignores conditions; deviation mode zeros
// - analog deviation/amount span -100% to 100%
// - negatives off: analog output reads zero
// - pid on only if action nonzero and, when assigned, input
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module pid_sleep_ctrl
    import pid_sleep_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // pid calculation side
    input wire logic [15:0] pid_freq_i,
    input wire pid_quant_t quant_i,
    input wire logic freq_at_upper_i,
    input wire logic freq_at_lower_i,
    input wire logic deviation_input_mode_i,
    input wire logic pid_cond_ok_i,
    input wire logic run_request_i,
    input wire logic pid_enable_input_i,
    // output stage
    input wire logic decel_done_i,
    output logic coast_stop_o,
    output logic decel_stop_o,
    output logic integral_hold_o,
    output logic signed [16:0] manip_floor_o,
    // status terminals and monitors
    output logic motor_running_o,
    output logic pid_active_flag_o,
    output logic sleep_flag_o,
    output logic sleep_terminal_o,
    output monitor_out_t monitor_o,
    output logic irq_o
);
    // =========================================================
    // registers
    logic [15:0] pid_action_select_q;
    logic [15:0] sleep_detect_time_q;
    logic [15:0] sleep_detect_level_q;
    logic [15:0] sleep_release_level_q;
    logic [7:0] pid_fault_action_select_q;
    logic [1:0] integral_hold_select_q;
    logic negative_monitor_select_q;
    logic en_assigned_q;
    logic [23:0] mon_sel_q;
    logic [7:0] term_func_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic ack_q;
    logic [31:0] rdata_q;
    sleep_state_t state_q;
    sleep_state_t state_d;
    logic [31:0] tick_cnt_q;
    logic [15:0] det_cnt_q;
    logic [15:0] det_cnt_d;
    logic hold_prev_q;
    monitor_out_t mon_q;

    // =========================================================
    // bus decode: one wait state, access taken when ack_q is high
    wire req = avs_read_i | avs_write_i;
    wire take = req & ack_q;
    wire wr = avs_write_i & ack_q;
    wire rd_clr = avs_read_i & ack_q & (avs_address_i == OFS_IRQ_STAT);
    wire [31:0] status_word = {27'h0, integral_hold_o, pid_active_flag_o, sleep_flag_o, state_q};
    logic [31:0] rmux;
    always_comb
    begin
        if (avs_address_i == OFS_ACTION) rmux = {16'h0, pid_action_select_q};
        else if (avs_address_i == OFS_DET_TIME) rmux = {16'h0, sleep_detect_time_q};
        else if (avs_address_i == OFS_DET_LEVEL) rmux = {16'h0, sleep_detect_level_q};
        else if (avs_address_i == OFS_REL_LEVEL) rmux = {16'h0, sleep_release_level_q};
        else if (avs_address_i == OFS_FAULT_ACT) rmux = {24'h0, pid_fault_action_select_q};
        else if (avs_address_i == OFS_HOLD_SEL) rmux = {30'h0, integral_hold_select_q};
        else if (avs_address_i == OFS_NEG_SEL) rmux = {31'h0, negative_monitor_select_q};
        else if (avs_address_i == OFS_CTRL) rmux = {31'h0, en_assigned_q};
        else if (avs_address_i == OFS_MON_SEL) rmux = {8'h0, mon_sel_q};
        else if (avs_address_i == OFS_TERM_FUNC) rmux = {24'h0, term_func_q};
        else if (avs_address_i == OFS_STATUS) rmux = status_word;
        else if (avs_address_i == OFS_IRQ_STAT) rmux = {29'h0, irq_stat_q};
        else if (avs_address_i == OFS_IRQ_MASK) rmux = {29'h0, irq_mask_q};
        else rmux = 32'h0;
    end
    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o = rdata_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (avs_read_i & ~ack_q)
                rdata_q <= rmux;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pid_action_select_q <= RST_ACTION;
            sleep_detect_time_q <= RST_DET_TIME;
            sleep_detect_level_q <= 16'h0000;
            sleep_release_level_q <= 16'h0000;
            pid_fault_action_select_q <= 8'h00;
            integral_hold_select_q <= HOLD_LIMIT_PM;
            negative_monitor_select_q <= 1'b0;
            en_assigned_q <= 1'b0;
            mon_sel_q <= 24'h0;
            term_func_q <= 8'h00;
            irq_mask_q <= 3'h0;
        end
        else if (wr)
        begin
            if (avs_address_i == OFS_ACTION) pid_action_select_q <= avs_writedata_i[15:0];
            if (avs_address_i == OFS_DET_TIME) sleep_detect_time_q <= avs_writedata_i[15:0];
            if (avs_address_i == OFS_DET_LEVEL) sleep_detect_level_q <= avs_writedata_i[15:0];
            if (avs_address_i == OFS_REL_LEVEL) sleep_release_level_q <= avs_writedata_i[15:0];
            if (avs_address_i == OFS_FAULT_ACT) pid_fault_action_select_q <= avs_writedata_i[7:0];
            if (avs_address_i == OFS_HOLD_SEL) integral_hold_select_q <= avs_writedata_i[1:0];
            if (avs_address_i == OFS_NEG_SEL) negative_monitor_select_q <= avs_writedata_i[0];
            if (avs_address_i == OFS_CTRL) en_assigned_q <= avs_writedata_i[CTRL_EN_ASSIGNED];
            if (avs_address_i == OFS_MON_SEL) mon_sel_q <= avs_writedata_i[23:0];
            if (avs_address_i == OFS_TERM_FUNC) term_func_q <= avs_writedata_i[7:0];
            if (avs_address_i == OFS_IRQ_MASK) irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
        end
    end

    // =========================================================
    // pid enable and sleep conditions
    wire pid_en = (pid_action_select_q != 16'h0) & (~en_assigned_q | pid_enable_input_i);
    wire sleep_on = sleep_detect_time_q != DET_TIME_OFF;
    wire freq_low = pid_freq_i < sleep_detect_level_q;
    wire signed [16:0] release_lvl = $signed({1'b0, sleep_release_level_q}) - PCT_1000;
    // signed compare: release level may sit below zero
    wire released = 17'(quant_i.deviation) >= release_lvl;
    wire decel_sel = (pid_fault_action_select_q >= FAULT_DECEL_MIN)
        & (pid_fault_action_select_q <= FAULT_DECEL_MAX);
    wire det_done = det_cnt_q >= sleep_detect_time_q;
    wire tick = tick_cnt_q == 32'(TICK_CYC - 1);

    // tick divider for the detection timer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end

    // =========================================================
    // sleep state machine
    always_comb
    begin
        state_d = state_q;
        det_cnt_d = det_cnt_q;
        case (state_q)
            S_RUN:
            begin
                if (!freq_low || !sleep_on || !pid_en)
                    det_cnt_d = 16'h0;
                else if (det_done)
                begin
                    det_cnt_d = 16'h0;
                    state_d = decel_sel ? S_DECEL : S_SLEEP;
                end
                else if (tick)
                    det_cnt_d = det_cnt_q + 16'h1;
            end
            S_DECEL:
            begin
                // detection level not looked at while ramping down
                if (!sleep_on || !pid_en || released)
                    state_d = S_RUN;
                else if (decel_done_i)
                    state_d = S_SLEEP;
            end
            S_SLEEP:
            begin
                if (!sleep_on || !pid_en || released)
                    state_d = S_RUN;
            end
            default:
                state_d = S_RUN;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= S_RUN;
            det_cnt_q <= 16'h0;
        end
        else
        begin
            state_q <= state_d;
            det_cnt_q <= det_cnt_d;
        end
    end

    wire asleep = state_q != S_RUN;
    // no stale sleep flag once pid is off
    assign sleep_flag_o = asleep & sleep_on & pid_en;
    assign motor_running_o = run_request_i & ~asleep;
    assign pid_active_flag_o = pid_en & (run_request_i | asleep);
    assign coast_stop_o = state_q == S_SLEEP;
    assign decel_stop_o = state_q == S_DECEL;
    assign sleep_terminal_o = (term_func_q == TERM_POS) ? sleep_flag_o
        : (term_func_q == TERM_NEG) ? ~sleep_flag_o : 1'b0;

    // =========================================================
    // integral hold
    wire signed [16:0] manip = 17'(quant_i.manip);
    wire at_pos = manip >= PCT_100;
    wire at_neg = manip <= -PCT_100;
    wire at_zero = manip <= PCT_0;
    wire lim = freq_at_upper_i | freq_at_lower_i;
    assign integral_hold_o = pid_en & (
        (integral_hold_select_q == HOLD_NONE) ? (freq_at_upper_i | at_pos | at_neg)
        : (integral_hold_select_q == HOLD_LIMIT_POS) ? (lim | at_pos | at_zero)
        : (lim | at_pos | at_neg));
    assign manip_floor_o = (integral_hold_select_q == HOLD_LIMIT_POS) ? PCT_0 : -PCT_100;

    // =========================================================
    // monitors
    function automatic logic signed [16:0] pick(input logic [7:0] code, input pid_quant_t q,
        input logic dev_mode, input logic cond_ok);
        logic signed [16:0] v;
        v = 17'sh0;
        if (code == MON_SET_POINT) v = dev_mode ? 17'sh0 : 17'(q.set_point);
        else if (code == MON_MEASURED) v = (dev_mode | ~cond_ok) ? 17'sh0 : 17'(q.measured);
        else if (code == MON_MEASURED2) v = dev_mode ? 17'sh0 : 17'(q.measured);
        else if (code == MON_DEVIATION) v = 17'(q.deviation);
        else if (code == MON_MANIP) v = 17'(q.manip);
        return v;
    endfunction

    wire [7:0] panel_code = mon_sel_q[MON_PANEL_LSB +: 8];
    wire [7:0] analog_code = mon_sel_q[MON_ANALOG_LSB +: 8];
    wire [7:0] pulse_code = mon_sel_q[MON_PULSE_LSB +: 8];
    wire panel_ofs = (panel_code == MON_DEVIATION) | (panel_code == MON_MANIP);
    wire analog_pm = (analog_code == MON_DEVIATION) | (analog_code == MON_MANIP);
    wire pulse_ok = (pulse_code == MON_SET_POINT) | (pulse_code == MON_MEASURED)
        | (pulse_code == MON_MEASURED2);
    wire signed [16:0] panel_raw = pick(panel_code, quant_i, deviation_input_mode_i, pid_cond_ok_i);
    wire signed [16:0] analog_raw = pick(analog_code, quant_i, deviation_input_mode_i, pid_cond_ok_i);
    wire signed [16:0] pulse_raw = pick(pulse_code, quant_i, deviation_input_mode_i, pid_cond_ok_i);
    wire signed [16:0] panel_sh = panel_raw + PCT_1000;
    wire signed [16:0] panel_v = !panel_ofs ? panel_raw : (panel_sh < PANEL_MIN) ? PANEL_MIN
        : (panel_sh > PANEL_MAX) ? PANEL_MAX : panel_sh;
    // clamp keeps the analog terminal inside its full-scale span for deviation and manip codes only
    wire signed [16:0] analog_cl = !analog_pm ? analog_raw : (analog_raw > PCT_100) ? PCT_100
        : (analog_raw < -PCT_100) ? -PCT_100 : analog_raw;
    wire signed [16:0] analog_v = (!negative_monitor_select_q && analog_cl < PCT_0) ? PCT_0 : analog_cl;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            mon_q <= '0;
        else
        begin
            mon_q.panel <= panel_v;
            mon_q.analog <= analog_v;
            mon_q.pulse <= pulse_ok ? pulse_raw : 17'sh0;
            mon_q.pulse_valid <= pulse_ok;
        end
    end
    assign monitor_o = mon_q;

    // =========================================================
    // interrupts: set wins over read-clear
    wire [IRQ_W-1:0] ev;
    assign ev[IRQ_SLEEP_IN] = (state_q == S_RUN) & (state_d != S_RUN);
    assign ev[IRQ_SLEEP_OUT] = (state_q != S_RUN) & (state_d == S_RUN);
    assign ev[IRQ_HOLD] = integral_hold_o & ~hold_prev_q;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_stat_q <= 3'h0;
            hold_prev_q <= 1'b0;
        end
        else
        begin
            // read clears only bits it returned
            irq_stat_q <= (irq_stat_q & ~({IRQ_W{rd_clr}} & rdata_q[IRQ_W-1:0])) | ev;
            hold_prev_q <= integral_hold_o;
        end
    end
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // =========================================================
    // assertions
    a_detect_elapsed: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_RUN && state_d != S_RUN) |-> (det_done && freq_low))
        else $error("sleep entered before detection time");

    a_release_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q != S_RUN && released) |=> state_q == S_RUN)
        else $error("release level did not wake");

    a_entry_kind: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_RUN && state_d != S_RUN) |=> (state_q == S_DECEL) == $past(decel_sel))
        else $error("wrong stop kind on sleep entry");

    a_off_no_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        !sleep_on |=> (state_q == S_RUN && !sleep_flag_o))
        else $error("sleep flag while function off");

    a_asleep_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_flag_o |-> (!motor_running_o && pid_active_flag_o))
        else $error("flags wrong while asleep");

    a_term_neg: assert property (@(posedge clk_i) disable iff (rst_i)
        term_func_q == TERM_NEG |-> sleep_terminal_o != sleep_flag_o)
        else $error("negative sleep terminal wrong");

    a_hold_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        (integral_hold_select_q == HOLD_NONE && !freq_at_upper_i && !at_pos && !at_neg) |-> !integral_hold_o)
        else $error("integral held with hold off");

    a_analog_neg: assert property (@(posedge clk_i) disable iff (rst_i)
        !negative_monitor_select_q ##1 !$past(negative_monitor_select_q) |-> monitor_o.analog >= PCT_0)
        else $error("negative analog output");

    a_pid_off: assert property (@(posedge clk_i) disable iff (rst_i)
        pid_action_select_q == 16'h0 |-> !pid_active_flag_o && !integral_hold_o)
        else $error("pid active with action zero");

    a_timer_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_RUN && !freq_low) |=> det_cnt_q == 16'h0)
        else $error("timer not restarted");

    c_coast: cover property (@(posedge clk_i) disable iff (rst_i) state_q == S_RUN ##1 state_q == S_SLEEP);
    c_decel_cancel: cover property (@(posedge clk_i) disable iff (rst_i) state_q == S_DECEL ##1 state_q == S_RUN);
    c_decel_done: cover property (@(posedge clk_i) disable iff (rst_i) state_q == S_DECEL ##1 state_q == S_SLEEP);
    c_sleep_wake: cover property (@(posedge clk_i) disable iff (rst_i) state_q == S_SLEEP ##1 state_q == S_RUN);
endmodule

// ==== verification/out_stage_model.sv ====
// output stage stand-in: ramps the motor down while a decel stop is asked
// assumes decel_stop_i comes from the block, synchronous to clk_i
`timescale 1ns/10ps
module out_stage_model #(
    parameter int STOP_CYC = 20
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // block side
    input wire logic decel_stop_i,
    output logic decel_done_o
);
    // =========================================================
    // ramp counter
    logic [7:0] ramp_q;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ramp_q <= 8'h00;
        else if (!decel_stop_i)
            ramp_q <= 8'h00; // re-acceleration restarts the ramp
        else if (ramp_q != 8'(STOP_CYC))
            ramp_q <= ramp_q + 8'h01;
    end
    // slow on purpose so a wake can land mid-ramp
    assign decel_done_o = decel_stop_i && (ramp_q == 8'(STOP_CYC));
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the pid sleep control block
// assumes the output stage model on decel; bus is avalon-mm, 250 MHz clock
`timescale 1ns/10ps
module tb;
    import pid_sleep_pkg::*;
    // =========================================================
    // signals and instances
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'h0, wr_en = 1'h0, upper = 1'h0, lower = 1'h0, dmode = 1'h0, cond = 1'h1, run = 1'h1;
    logic en_in = 1'h1;
    logic [31:0] wdat = 32'h0;
    logic [15:0] freq = 16'h00C8;
    pid_quant_t quant = '0;
    logic [31:0] rdat;
    logic wreq, done, coast, decel, hold, mrun, pida, slp, slp_t, irq;
    logic signed [16:0] floor;
    monitor_out_t mon;
    int err_total = 0;
    int checks = 0;
    pid_sleep_ctrl #(.TICK_CYC(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .pid_freq_i(freq), .quant_i(quant), .freq_at_upper_i(upper), .freq_at_lower_i(lower),
        .deviation_input_mode_i(dmode), .pid_cond_ok_i(cond), .run_request_i(run), .pid_enable_input_i(en_in),
        .decel_done_i(done), .coast_stop_o(coast), .decel_stop_o(decel), .integral_hold_o(hold),
        .manip_floor_o(floor), .motor_running_o(mrun), .pid_active_flag_o(pida), .sleep_flag_o(slp),
        .sleep_terminal_o(slp_t), .monitor_o(mon), .irq_o(irq));
    out_stage_model #(.STOP_CYC(20)) i_stage (.clk_i(clk_i), .rst_i(rst_i), .decel_stop_i(decel),
        .decel_done_o(done));
    // =========================================================
    // shared tasks
    task automatic chk(input logic signed [31:0] seen, input logic signed [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %0d wanted %0d", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 400)
        begin
            err_total++;
            $display("unexpected at %0t: wait ran out", $time);
            close_out();
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'h0 && n < 400);
        tmo(n);
        q = rdat;
        wr_en <= 1'h0;
        rd_en <= 1'h0;
    endtask
    task automatic await(input logic want_coast);
        int n;
        n = 0;
        while (((want_coast ? coast : (coast | decel)) !== 1'h1) && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        tmo(n);
    endtask
    task automatic wake(input logic [15:0] dv, input logic stay);
        @(posedge clk_i);
        freq <= 16'h00C8;
        quant.deviation <= dv;
        repeat (3) @(negedge clk_i);
        chk(coast | decel, stay);
        chk(mrun, !stay);
        @(posedge clk_i);
        quant.deviation <= 16'h0000;
    endtask
    task automatic h(input logic [1:0] sel, input logic up, input logic lo, input logic [15:0] mv, input logic e);
        logic [31:0] q;
        bus(1'h1, OFS_HOLD_SEL, {30'h0, sel}, q);
        @(posedge clk_i);
        upper <= up;
        lower <= lo;
        quant.manip <= mv;
        @(negedge clk_i);
        chk(hold, e);
        chk(floor, sel == HOLD_LIMIT_POS ? PCT_0 : -PCT_100);
    endtask
    task automatic m(input logic [23:0] codes, input logic signed [31:0] pn, an, pu, input logic pv);
        logic [31:0] q;
        bus(1'h1, OFS_MON_SEL, {8'h0, codes}, q);
        repeat (2) @(negedge clk_i);
        chk(mon.panel, pn);
        chk(mon.analog, an);
        chk(mon.pulse, pu);
        chk(mon.pulse_valid, pv);
        @(posedge clk_i);
    endtask
    // =========================================================
    // scenarios
    task automatic t_regs();
        logic [31:0] q;
        bus(1'h0, OFS_DET_TIME, 32'h0, q);
        chk(q, {16'h0, DET_TIME_OFF});
        bus(1'h1, 8'h3C, 32'hFF, q);
        bus(1'h0, 8'h3C, 32'h0, q);
        chk(q, 32'h0);
        chk(pida, 1'h0);
        $display("test regs done");
    endtask
    task automatic t_sleep();
        logic [31:0] q;
        bus(1'h1, OFS_ACTION, 32'h1, q);
        bus(1'h1, OFS_DET_LEVEL, 32'h64, q);
        bus(1'h1, OFS_REL_LEVEL, 32'h2774, q);
        bus(1'h1, OFS_IRQ_MASK, 32'h1, q);
        bus(1'h1, OFS_TERM_FUNC, {24'h0, TERM_POS}, q);
        bus(1'h1, OFS_DET_TIME, 32'h3, q);
        // 7 low cycles hold at most two ticks, short of the three needed
        repeat (6)
        begin
            freq <= 16'h0032;
            repeat (7) @(posedge clk_i);
            freq <= 16'h00C8;
            @(posedge clk_i);
        end
        freq <= 16'h0032;
        @(negedge clk_i);
        chk(slp, 1'h0);
        await(1'h1);
        chk(slp, 1'h1);
        chk(mrun, 1'h0);
        chk(pida, 1'h1);
        chk(slp_t, 1'h1);
        chk(irq, 1'h1);
        bus(1'h0, OFS_IRQ_STAT, 32'h0, q);
        chk(q, 32'h1);
        bus(1'h1, OFS_TERM_FUNC, {24'h0, TERM_NEG}, q);
        @(negedge clk_i);
        chk(irq, 1'h0);
        chk(slp_t, 1'h0);
        wake(16'h0063, 1'h1);
        wake(16'h0064, 1'h0);
        $display("test sleep done");
    endtask
    task automatic t_fault();
        logic [31:0] q;
        logic [7:0] fa [4] = '{8'h00, 8'h03, 8'h0A, 8'h0D};
        for (int i = 0; i < 4; i++)
        begin
            bus(1'h1, OFS_FAULT_ACT, {24'h0, fa[i]}, q);
            freq <= 16'h0032;
            await(1'h0);
            chk(decel, fa[i] >= FAULT_DECEL_MIN);
            if (i == 3)
                await(1'h1);
            chk(coast, i != 2);
            wake(16'h0063, 1'h1);
            wake(16'h0064, 1'h0);
        end
        $display("test fault done");
    endtask
    task automatic t_hold();
        h(HOLD_LIMIT_PM, 1'h0, 1'h1, 16'h0000, 1'h1);
        h(HOLD_NONE, 1'h0, 1'h1, 16'h0000, 1'h0);
        h(HOLD_NONE, 1'h1, 1'h0, 16'h0000, 1'h1);
        h(HOLD_NONE, 1'h0, 1'h0, 16'hFC18, 1'h1);
        h(HOLD_LIMIT_POS, 1'h0, 1'h0, 16'h0000, 1'h1);
        h(HOLD_LIMIT_PM, 1'h0, 1'h0, 16'h03E7, 1'h0);
        h(HOLD_LIMIT_PM, 1'h0, 1'h0, 16'h03E8, 1'h1);
        $display("test hold done");
    endtask
    task automatic t_mon();
        logic [31:0] q;
        @(posedge clk_i);
        quant <= {16'h012C, 16'h0190, 16'hFFCE, 16'h07D0};
        m({MON_DEVIATION, MON_MANIP, MON_DEVIATION}, PCT_1000 - 17'sh32, PCT_100, 32'h0, 1'h0);
        m({MON_SET_POINT, MON_DEVIATION, MON_MANIP}, PANEL_MAX, 32'h0, 32'h12C, 1'h1);
        bus(1'h1, OFS_NEG_SEL, 32'h1, q);
        m({MON_MEASURED, MON_DEVIATION, MON_MEASURED2}, 32'h190, -32'sh32, 32'h190, 1'h1);
        cond <= 1'h0;
        m({MON_MEASURED, MON_SET_POINT, MON_MEASURED2}, 32'h190, 32'h12C, 32'h0, 1'h1);
        dmode <= 1'h1;
        m({MON_SET_POINT, MON_MEASURED2, MON_SET_POINT}, 32'h0, 32'h0, 32'h0, 1'h1);
        $display("test monitor done");
    endtask
    task automatic t_off();
        logic [31:0] q;
        bus(1'h1, OFS_DET_TIME, {16'h0, DET_TIME_OFF}, q);
        freq <= 16'h0032;
        repeat (40) @(negedge clk_i);
        chk(slp | coast | decel, 1'h0);
        bus(1'h1, OFS_CTRL, 32'h1, q);
        en_in <= 1'h0;
        @(negedge clk_i);
        chk(pida, 1'h0);
        @(posedge clk_i);
        en_in <= 1'h1;
        @(negedge clk_i);
        chk(pida, 1'h1);
        $display("test disable done");
    endtask
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_sleep();
        t_fault();
        t_hold();
        t_mon();
        t_off();
        close_out();
    end
endmodule
